// *** src/cfg_reg_pkg.sv ***
package cfg_reg_pkg;

    // =========================================================
    // register layout
    // =========================================================
    localparam int unsigned CFG_WIDTH      = 12;
    localparam int unsigned LIST_WIDTH     = 8;
    localparam int unsigned POWER_HI_BIT   = 11;
    localparam int unsigned POWER_LO_BIT   = 10;
    localparam int unsigned CODING_BIT     = 9;
    localparam int unsigned REF_BIT        = 8;
    localparam int unsigned CHAN_HI_BIT    = 7;
    localparam int unsigned CHAN_LO_BIT    = 5;
    localparam int unsigned ARR_HI_BIT     = 4;
    localparam int unsigned ARR_LO_BIT     = 3;
    localparam int unsigned LIST_ACC_BIT   = 2;
    localparam int unsigned SCAN_BIT       = 1;
    localparam int unsigned RANGE_BIT      = 0;

    localparam logic [11:0] CFG_RESET      = 12'h000;
    localparam logic [7:0]  LIST_RESET     = 8'h00;
    localparam logic [2:0]  CHAN_FIRST     = 3'h0;

    // =========================================================
    // timing
    // =========================================================
    localparam int unsigned CLOCK_PERIOD_NS  = 10;
    localparam int unsigned STANDBY_WAKE_NS  = 1000;
    localparam int unsigned STANDBY_WAKE_CYC = STANDBY_WAKE_NS / CLOCK_PERIOD_NS;
    localparam logic [7:0]  WAKE_COUNT       = 8'(STANDBY_WAKE_CYC);
    localparam logic [7:0]  WAKE_ZERO        = 8'h00;

    // =========================================================
    // field encodings
    // =========================================================
    typedef enum logic [1:0] {
        PWR_STANDBY  = 2'b00,
        PWR_AUTO_OFF = 2'b01,
        PWR_SHUTDOWN = 2'b10,
        PWR_NORMAL   = 2'b11
    } power_mode_t;

    typedef enum logic [1:0] {
        ARR_SINGLE8  = 2'b00,
        ARR_DIFF4    = 2'b01,
        ARR_PSEUDO4  = 2'b10,
        ARR_PSEUDO7  = 2'b11
    } input_arr_t;

    typedef enum logic [1:0] {
        SEQ_OFF      = 2'b00,
        SEQ_KEEP     = 2'b01,
        SEQ_LIST_WR  = 2'b10,
        SEQ_CONSEC   = 2'b11
    } seq_mode_t;

    // decoded configuration
    typedef struct packed {
        power_mode_t power;
        logic        straight_binary;
        logic        external_ref;
        logic [2:0]  channel;
        input_arr_t  arrangement;
        seq_mode_t   seq;
        logic        double_range;
    } cfg_t;

    // power controls for the analog side
    typedef struct packed {
        logic core_on;
        logic ref_on;
        logic waking;
    } power_ctl_t;

endpackage : cfg_reg_pkg

// *** src/cfg_reg_decode.sv ***
`timescale 1ns/1ns
module cfg_reg_decode (
    // clock, reset and enable
    input  wire logic                            i_clock,
    input  wire logic                            i_reset_n,
    input  wire logic                            i_enable,
    // parallel write port
    input  wire logic                            i_cs_n,
    input  wire logic                            i_wr_n,
    input  wire logic [11:0]                     i_data,
    // conversion events
    input  wire logic                            i_conv_start,
    input  wire logic                            i_conv_done,
    // decoded configuration
    output logic      [11:0]                     o_cfg_word,
    output logic                                 o_straight_binary,
    output logic                                 o_external_ref,
    output logic                                 o_double_range,
    output logic      [1:0]                      o_arrangement,
    output logic      [1:0]                      o_seq_mode,
    output logic      [2:0]                      o_channel,
    output logic      [7:0]                      o_channel_list,
    output logic                                 o_list_loaded,
    // power controls
    output logic                                 o_core_on,
    output logic                                 o_ref_on,
    output logic                                 o_waking
);

    // =========================================================
    // write strobe detection
    // =========================================================
    logic              wr_n_q;
    logic              cs_n_q;
    logic              write_done;
    logic [11:0]       cfg;
    logic [11:0]       data_q;
    logic              list_armed;
    logic              cfg_loaded;
    logic [7:0]        list;
    logic [2:0]        channel;
    logic [7:0]        wake_cnt;
    logic              asleep;
    cfg_reg_pkg::cfg_t f;

    assign f = cfg_reg_pkg::cfg_t'(cfg);

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            wr_n_q <= 1'b1;
            cs_n_q <= 1'b1;
            data_q <= cfg_reg_pkg::CFG_RESET;
        end else if (i_enable) begin
            wr_n_q <= i_wr_n;
            cs_n_q <= i_cs_n;
            data_q <= i_data;
        end
    end

    // rising edge of the strobe while selected
    assign write_done = !wr_n_q && i_wr_n && !cs_n_q;

    // =========================================================
    // configuration and list registers
    // =========================================================
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            cfg        <= cfg_reg_pkg::CFG_RESET;
            list_armed <= 1'b0;
        end else if (i_enable && write_done) begin
            if (list_armed) begin
                list_armed <= 1'b0;
            end else begin
                cfg        <= data_q;
                list_armed <= data_q[cfg_reg_pkg::SCAN_BIT:cfg_reg_pkg::LIST_ACC_BIT - 1] == 1'b0
                              && data_q[cfg_reg_pkg::LIST_ACC_BIT];
            end
        end
    end

    // one cycle after a configuration load, when the new fields apply
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            cfg_loaded <= 1'b0;
        end else if (i_enable) begin
            cfg_loaded <= write_done && !list_armed;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            list          <= cfg_reg_pkg::LIST_RESET;
            o_list_loaded <= 1'b0;
        end else if (i_enable) begin
            o_list_loaded <= write_done && list_armed;
            if (write_done && list_armed) begin
                list <= data_q[cfg_reg_pkg::LIST_WIDTH - 1:0];
            end
        end
    end

    // =========================================================
    // channel selection
    // =========================================================
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            channel <= cfg_reg_pkg::CHAN_FIRST;
        end else if (i_enable) begin
            unique case (f.seq)
                cfg_reg_pkg::SEQ_CONSEC: begin
                    if (cfg_loaded) begin
                        channel <= cfg_reg_pkg::CHAN_FIRST;
                    end else if (i_conv_done) begin
                        channel <= (channel == f.channel) ? cfg_reg_pkg::CHAN_FIRST
                                                          : channel + 3'h1;
                    end
                end
                cfg_reg_pkg::SEQ_KEEP: begin
                    if (i_conv_done) begin
                        channel <= channel + 3'h1;
                    end
                end
                default: begin
                    channel <= f.channel;
                end
            endcase
        end
    end

    // =========================================================
    // power management
    // =========================================================
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            asleep   <= 1'b0;
            wake_cnt <= cfg_reg_pkg::WAKE_ZERO;
        end else if (i_enable) begin
            unique case (f.power)
                cfg_reg_pkg::PWR_NORMAL: begin
                    asleep   <= 1'b0;
                    wake_cnt <= cfg_reg_pkg::WAKE_ZERO;
                end
                cfg_reg_pkg::PWR_SHUTDOWN: begin
                    asleep   <= 1'b1;
                    wake_cnt <= cfg_reg_pkg::WAKE_ZERO;
                end
                default: begin
                    if (i_conv_done) begin
                        asleep <= 1'b1;
                    end else if (i_conv_start && asleep) begin
                        asleep   <= 1'b0;
                        wake_cnt <= cfg_reg_pkg::WAKE_COUNT;
                    end else if (wake_cnt != cfg_reg_pkg::WAKE_ZERO) begin
                        wake_cnt <= wake_cnt - 8'h01;
                    end
                end
            endcase
        end
    end

    // =========================================================
    // registered outputs
    // =========================================================
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_cfg_word        <= cfg_reg_pkg::CFG_RESET;
            o_straight_binary <= 1'b0;
            o_external_ref    <= 1'b0;
            o_double_range    <= 1'b0;
            o_arrangement     <= 2'b00;
            o_seq_mode        <= 2'b00;
            o_channel         <= cfg_reg_pkg::CHAN_FIRST;
            o_channel_list    <= cfg_reg_pkg::LIST_RESET;
            o_core_on         <= 1'b0;
            o_ref_on          <= 1'b0;
            o_waking          <= 1'b0;
        end else if (i_enable) begin
            o_cfg_word        <= cfg;
            o_straight_binary <= f.straight_binary;
            o_external_ref    <= f.external_ref;
            o_double_range    <= f.double_range;
            o_arrangement     <= f.arrangement;
            o_seq_mode        <= f.seq;
            o_channel         <= channel;
            o_channel_list    <= list;
            o_core_on         <= !asleep;
            o_ref_on          <= !asleep || (f.power == cfg_reg_pkg::PWR_STANDBY);
            o_waking          <= wake_cnt != cfg_reg_pkg::WAKE_ZERO;
        end
    end

endmodule : cfg_reg_decode

// *** verification/cfg_reg_decode_sva.sv ***
`timescale 1ns/1ns
// ==========
// configuration register checker
module cfg_reg_decode_sva (
    // clock and control
    input logic        i_clock,
    input logic        i_reset_n,
    input logic        i_enable,
    // write port and events
    input logic        i_cs_n,
    input logic        i_wr_n,
    input logic [11:0] i_data,
    input logic        i_conv_start,
    input logic        i_conv_done,
    // decoded outputs
    input logic [11:0] o_cfg_word,
    input logic        o_straight_binary,
    input logic        o_external_ref,
    input logic        o_double_range,
    input logic [1:0]  o_arrangement,
    input logic [1:0]  o_seq_mode,
    input logic [2:0]  o_channel,
    input logic [7:0]  o_channel_list,
    input logic        o_list_loaded,
    input logic        o_core_on,
    input logic        o_ref_on
);
    logic        wr_q, cs_q, pend, take;
    logic [11:0] d_q, last;
    assign take = i_enable && !wr_q && !cs_q && i_wr_n;
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            wr_q <= 1'b1;
            cs_q <= 1'b1;
        end else if (i_enable) begin
            wr_q <= i_wr_n;
            cs_q <= i_cs_n;
            d_q  <= i_data;
        end
    end
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            pend <= 1'b0;
        end else if (take) begin
            pend <= !pend && d_q[2:1] == 2'b10;
            last <= d_q;
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    sequence took_s; take && !pend; endsequence
    sequence list_s; take && pend; endsequence
    cfg_load_a: assert property (took_s |-> ##2 o_cfg_word == last)
        else $error("configuration word not loaded");
    field_map_a: assert property (o_straight_binary == o_cfg_word[9] && o_external_ref ==
        o_cfg_word[8] && o_double_range == o_cfg_word[0] && o_arrangement == o_cfg_word[4:3]
        && o_seq_mode == o_cfg_word[2:1])
        else $error("decoded field differs from word");
    cs_refuse_a: assert property (i_cs_n[*5] |-> $stable(o_cfg_word))
        else $error("word changed without chip select");
    list_load_a: assert property (list_s |-> ##2 o_channel_list == last[7:0]
        && $stable(o_cfg_word)) else $error("channel list write wrong");
    list_pulse_a: assert property (list_s |-> ##[1:3] o_list_loaded)
        else $error("list load pulse missing");
    chan_direct_a: assert property (took_s ##0 d_q[2:1] == 2'b00 |->
        ##3 o_channel == last[7:5]) else $error("channel address not applied");
    normal_pwr_a: assert property ((o_cfg_word[11:10] == 2'b11)[*3] |-> o_core_on && o_ref_on)
        else $error("normal mode not fully powered");
    shut_pwr_a: assert property ((o_cfg_word[11:10] == 2'b10)[*3] |-> !o_core_on && !o_ref_on)
        else $error("shutdown left circuitry on");
    auto_off_a: assert property (i_conv_done && o_cfg_word[11:10] == 2'b01 |->
        ##[1:3] !o_core_on && !o_ref_on) else $error("auto shutdown missed");
    standby_a: assert property (i_conv_done && o_cfg_word[11:10] == 2'b00 |->
        ##[1:3] !o_core_on && o_ref_on) else $error("auto standby wrong");
    wake_up_a: assert property (i_conv_start && !o_core_on && !o_cfg_word[11] |->
        ##[1:3] o_core_on) else $error("no wake on conversion start");
endmodule : cfg_reg_decode_sva
bind cfg_reg_decode cfg_reg_decode_sva cfg_reg_decode_sva_i (.i_clock, .i_reset_n, .i_enable,
    .i_cs_n, .i_wr_n, .i_data, .i_conv_start, .i_conv_done, .o_cfg_word, .o_straight_binary,
    .o_external_ref, .o_double_range, .o_arrangement, .o_seq_mode, .o_channel, .o_channel_list,
    .o_list_loaded, .o_core_on, .o_ref_on);

// *** verification/cfg_host.sv ***
`timescale 1ns/1ns
// ==========
// host parallel write model
module cfg_host (
    // clock
    input  logic        i_clock,
    // parallel write port
    output logic        o_cs_n,
    output logic        o_wr_n,
    output logic [11:0] o_data
);
    initial begin
        o_cs_n = 1'b1;
        o_wr_n = 1'b1;
        o_data = 12'hfff;
    end
    task automatic put(input logic [11:0] w, input logic sel_n, input int hold);
        @(posedge i_clock);
        #1;
        o_cs_n = sel_n;
        o_wr_n = 1'b0;
        o_data = w;
        repeat (hold) @(posedge i_clock);
        @(posedge i_clock);
        #1;
        o_wr_n = 1'b1;
        @(posedge i_clock);
        #1;
        o_cs_n = 1'b1;
        o_data = ~w;
    endtask : put
endmodule : cfg_host

// *** verification/cfg_reg_decode_test.sv ***
`timescale 1ns/1ns
module cfg_reg_decode_test;
    // ==========
    // signals
    logic i_clock = 1'b0, i_reset_n, i_enable, i_cs_n, i_wr_n, i_conv_start, i_conv_done;
    logic [11:0] i_data, o_cfg_word, w;
    logic o_straight_binary, o_external_ref, o_double_range, o_list_loaded;
    logic o_core_on, o_ref_on, o_waking;
    logic [1:0] o_arrangement, o_seq_mode, pw;
    logic [2:0] o_channel;
    logic [7:0] o_channel_list;
    int n_mismatch = 0, samples_checked = 0, cycles = 0;
    always #5 i_clock = ~i_clock;
    cfg_reg_decode cfg_reg_decode_i (.i_clock, .i_reset_n, .i_enable, .i_cs_n, .i_wr_n, .i_data,
        .i_conv_start, .i_conv_done, .o_cfg_word, .o_straight_binary, .o_external_ref,
        .o_double_range, .o_arrangement, .o_seq_mode, .o_channel, .o_channel_list,
        .o_list_loaded, .o_core_on, .o_ref_on, .o_waking);
    cfg_host cfg_host_i (.i_clock, .o_cs_n(i_cs_n), .o_wr_n(i_wr_n), .o_data(i_data));
    // ==========
    // tasks
    task chk(input logic [11:0] seen, input logic [11:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task wr(input logic [11:0] v, input logic sel_n = 1'b0, input int hold = 0);
        cfg_host_i.put(v, sel_n, hold);
        repeat (3) @(posedge i_clock);
        #2;
    endtask : wr
    task ev(input logic done);
        @(posedge i_clock);
        #1;
        i_conv_start = !done;
        i_conv_done = done;
        @(posedge i_clock);
        #1;
        i_conv_start = 1'b0;
        i_conv_done = 1'b0;
        repeat (4) @(posedge i_clock);
        #2;
    endtask : ev
    task final_report;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : final_report
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            final_report;
        end
    end
    // ==========
    // tests
    initial begin
        i_reset_n = 1'b0;
        i_enable = 1'b1;
        i_conv_start = 1'b0;
        i_conv_done = 1'b0;
        repeat (2) @(posedge i_clock);
        #1;
        i_reset_n = 1'b1;
        repeat (2) @(posedge i_clock);
        #2;
        chk(o_cfg_word, 12'h000);
        for (int i = 0; i < 4; i++) begin
            w = {2'(i), i[0], !i[0], 3'(i * 3), 2'(i), 2'b00, i[1]};
            pw = (i == 3) ? 2'b11 : (i == 0) ? 2'b01 : 2'b00;
            wr(w);
            chk(o_cfg_word, w);
            chk(12'({o_straight_binary, o_external_ref, o_arrangement, o_double_range}),
                12'({w[9], w[8], w[4:3], w[0]}));
            chk(12'(o_channel), 12'(w[7:5]));
            ev(1'b1);
            chk(12'(o_channel), 12'(w[7:5]));
            chk(12'({o_core_on, o_ref_on}), 12'(pw));
            if (!w[11]) begin
                ev(1'b0);
                chk(12'({o_core_on, o_waking}), 12'h003);
            end
        end
        $display("test fields finished");
        wr(12'h555, 1'b1);
        chk(o_cfg_word, w);
        wr(12'hc04, 1'b0, 2);
        chk(12'(o_seq_mode), 12'h002);
        wr(12'h3a5);
        chk(12'(o_channel_list), 12'h0a5);
        chk(o_cfg_word, 12'hc04);
        wr(12'hc66);
        chk(o_cfg_word, 12'hc66);
        chk(12'(o_seq_mode), 12'h003);
        $display("test list finished");
        chk(12'(o_channel), 12'h000);
        for (int k = 1; k < 6; k++) begin
            ev(1'b1);
            chk(12'(o_channel), 12'(k % 4));
        end
        wr(12'hc62);
        chk(12'(o_seq_mode), 12'h001);
        chk(12'(o_channel), 12'h001);
        ev(1'b1);
        chk(12'(o_channel), 12'h002);
        $display("test scan finished");
        @(posedge i_clock);
        #1;
        i_reset_n = 1'b0;
        repeat (2) @(posedge i_clock);
        #1;
        i_reset_n = 1'b1;
        repeat (2) @(posedge i_clock);
        #2;
        chk(o_cfg_word, 12'h000);
        chk(12'(o_channel_list), 12'h000);
        chk(12'(o_channel), 12'h000);
        $display("test reset finished");
        final_report;
    end
endmodule : cfg_reg_decode_test
